/* File: verilog/smre_top.sv */
// smre_top: serial-bus slave that writes volatile registers and eeprom,
// erases eeprom pages and keeps the pointer for later reads.
// assumes scl/sda are external pins sampled by a 10 MHz clock; sda is
// open-drain and the bench resolves the wire from sda_oe.
// Operation
// - eeprom bits only programmable from erased state
// - command a2h plus page location erases
// - sixteen 32-byte pages, defaults page 8100h
// - page from high byte and low-byte top bits
// - erase ignores low five address bits
// - erase lasts about 20 ms
// - eeprom access during erase gets nack
// - send byte: address, command acked, stop
// - send byte loads register address pointer
// - repeated start after last ack accepted
// - write byte/word: command, one or two data
// - command value selects register, pointer, or program
// - command 00h-7fh writes one volatile register
// - eeprom high byte plus one byte sets pointer
// - high byte plus two bytes programs eeprom
// - single byte program needs control bit set
// - command a0h: count then data bytes
// - block count up to 32, all acked; code nacks an eeprom block byte while the previous one programs
// - each byte programs in about 350 us
// - block write never crosses a page
// - registers 00h-7fh, eeprom 8000h-813fh
// - pointer halts at area end, writes dropped
`timescale 1ns/1ns
`default_nettype none
module smre_top
  import smre_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYC_DEF   // erase busy cycles, shorten in sim
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       scl_in,       // bus clock pin level
  input  wire logic       sda_in,       // bus data pin level
  input  wire logic [6:0] dev_addr,     // slave address straps
  output var  logic       sda_out,      // always low when driven
  output var  logic       sda_oe,       // high pulls sda low
  output var  logic       erase_busy,   // page erase in progress
  output var  logic       prog_busy     // byte programming in progress
);
  // =====================================================================
  // pin sampling
  logic [8:0] pins_s;      // synchronised scl, sda, address
  logic       scl_p;       // previous scl sample
  logic       sda_p;       // previous sda sample
  smre_sync #(.W(9)) u_sync (
    .clock   (clock),
    .reset_n (reset_n),
    .d       ({scl_in, sda_in, dev_addr}),
    .q       (pins_s)
  );
  wire       scl_s    = pins_s[8];
  wire       sda_s    = pins_s[7];
  wire [6:0] addr_s   = pins_s[6:0];
  wire       scl_rise = scl_s & ~scl_p;
  wire       scl_fall = ~scl_s & scl_p;
  // start and stop only when scl stays high over both samples
  wire       bus_start = scl_s & scl_p & sda_p & ~sda_s;
  wire       bus_stop  = scl_s & scl_p & ~sda_p & sda_s;
  // edge history; reset parks it at the idle-high bus level
  always_ff @(posedge clock) begin
    scl_p <= scl_s | ~reset_n;
    sda_p <= sda_s | ~reset_n;
  end
  // =====================================================================
  // transaction state
  smre_st_t   st_q;        // bit level state
  smre_idx_t  idx_q;       // byte position in the transfer
  logic [2:0] bit_q;       // bit counter
  logic [6:0] sh_q;        // receive shifter
  logic [7:0] tx_q;        // transmit shifter
  logic       ack_q;       // decided answer for the last byte
  logic       ackon_q;     // ack bit slot is being driven
  logic       rd_q;        // current transfer is a read
  logic [7:0] cmd_q;       // command byte
  logic [7:0] lo_q;        // first data byte (count or erase high byte)
  logic [5:0] dcnt_q;      // data bytes after the first
  logic [15:0] ptr_q;      // register / eeprom address pointer
  logic       dead_q;      // pointer ran off its page or area
  logic       wen_q;       // copy of control bit for single programming
  smre_nv_t   nv_q;        // eeprom engine state
  logic [NV_CNT_W-1:0] nv_cnt_q;  // busy countdown
  logic [5:0] wipe_q;      // erase write index
  logic [8:0] paddr_q;     // eeprom target index
  logic [7:0] pdata_q;     // byte being programmed
  logic [7:0] ram_rd;      // register read data
  logic [7:0] eep_rd;      // eeprom read data
  wire [7:0] b         = {sh_q, sda_s};            // byte just completed
  wire       byte_done = (st_q == S_RX) & scl_rise & (bit_q == 3'h7);
  wire       nv_busy   = (nv_q != NV_IDLE);
  wire       b_eep     = (b == HI_USER) | (b == HI_DFLT);
  wire       cmd_ram   = ~cmd_q[7];
  wire       cmd_eep   = (cmd_q == HI_USER) | (cmd_q == HI_DFLT);
  // valid pointer windows
  wire       ptr_ram   = (ptr_q[15:8] == HI_RAM) & ~ptr_q[7];
  wire       ptr_eep   = (ptr_q[15:8] == HI_USER) |
                         ((ptr_q[15:8] == HI_DFLT) & (ptr_q[7:0] <= DFLT_END_LO));
  wire       ptr_live  = ~dead_q & (ptr_ram | ptr_eep);
  wire       ptr_end   = ptr_ram ? (ptr_q[6:0] == RAM_END) : (ptr_q[4:0] == PAGE_END);
  wire [8:0] ptr_idx   = {ptr_q[8], ptr_q[7:0]};
  wire [7:0] rd_byte   = ~ptr_live ? 8'h00 : (ptr_ram ? ram_rd : eep_rd);
  // =====================================================================
  // byte decode
  logic       ack_n;      // answer for the byte completing now
  logic       ram_w;      // write a register
  logic [6:0] ram_a;      // register address
  logic       prog_go;    // start byte programming
  logic       era_go;     // start page erase
  logic       ptr_ld;     // load the pointer
  logic [15:0] ptr_nx;    // value to load
  logic       step;       // advance pointer after a block byte
  // what the completed byte means at its position
  always_comb begin
    ack_n   = 1'b1;
    ram_w   = 1'b0;
    ram_a   = cmd_q[6:0];
    prog_go = 1'b0;
    era_go  = 1'b0;
    ptr_ld  = 1'b0;
    ptr_nx  = ptr_q;
    step    = 1'b0;
    unique case (idx_q)
      IDX_ADDR: begin
        // reads of eeprom wait out erase and programming
        ack_n = (b[7:1] == addr_s) & ~(b[0] & nv_busy & ptr_q[15]);
      end
      IDX_CMD: begin
        ack_n = ~(nv_busy & (b_eep | (b == CMD_ERASE)));
        if (~b[7]) begin
          ptr_ld = 1'b1;
          ptr_nx = {HI_RAM, b};
        end
      end
      IDX_D1: begin
        if (cmd_ram) begin
          ram_w = 1'b1;
        end else if (cmd_eep) begin
          ptr_ld = 1'b1;
          ptr_nx = {cmd_q, b};
        end else if (cmd_q == CMD_ERASE) begin
          ack_n = b_eep;
        end else if (cmd_q == CMD_BLK_WR) begin
          ack_n = (b != 8'h00) & (b <= BLK_MAX);
        end
      end
      IDX_D2: begin
        if (cmd_eep) begin
          // one program per transfer, only when enabled and idle
          ack_n   = ~nv_busy & (dcnt_q == 6'h00);
          prog_go = ack_n & wen_q & ptr_live;
        end else if (cmd_q == CMD_ERASE) begin
          ack_n  = ~nv_busy & (dcnt_q == 6'h00);
          era_go = ack_n;
        end else if (cmd_q == CMD_BLK_WR) begin
          ack_n = ({2'b00, dcnt_q} < lo_q) & ~(ptr_q[15] & nv_busy);
          step  = ack_n & ptr_live;
          ram_w = step & ptr_ram;
          ram_a = ptr_q[6:0];
          prog_go = step & ~ptr_ram;
        end
      end
    endcase
  end
  // memory write ports
  smre_wr_t ram_wr;   // register write
  smre_wr_t eep_wr;   // eeprom write
  assign ram_wr = '{en: byte_done & ram_w, addr: {2'b00, ram_a}, data: b};
  // programming can only clear bits: a cell is written as old and new
  assign eep_wr = (nv_q == NV_ERASE) ?
                  '{en: ~wipe_q[5], addr: paddr_q | {4'h0, wipe_q[4:0]}, data: ERASED} :
                  '{en: (nv_q == NV_PROG) & (nv_cnt_q == NV_CNT_W'(1)),
                    addr: paddr_q, data: eep_rd & pdata_q};
  wire [8:0] eep_ra = (nv_q == NV_PROG) ? paddr_q : ptr_idx;
  smre_mem #(.AW(7)) u_ram (
    .clock (clock),
    .wr    (ram_wr),
    .raddr (ptr_q[6:0]),
    .rdata (ram_rd)
  );
  // 512 cells cover all sixteen pages
  smre_mem #(.AW(9)) u_eep (
    .clock (clock),
    .wr    (eep_wr),
    .raddr (eep_ra),
    .rdata (eep_rd)
  );
  // =====================================================================
  // bit and byte sequencer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      st_q    <= S_IDLE;
      idx_q   <= IDX_ADDR;
      bit_q   <= 3'h0;
      sh_q    <= 7'h00;
      tx_q    <= 8'h00;
      sda_oe  <= 1'b0;
      ackon_q <= 1'b0;
    end else if (bus_start) begin
      // repeated start is a fresh transfer with the pointer kept
      st_q    <= S_RX;
      idx_q   <= IDX_ADDR;
      bit_q   <= 3'h0;
      sda_oe  <= 1'b0;
      ackon_q <= 1'b0;
    end else if (bus_stop) begin
      st_q    <= S_IDLE;
      sda_oe  <= 1'b0;
      ackon_q <= 1'b0;
    end else begin
      unique case (st_q)
        S_IDLE, S_SKIP: begin end  // wait for start or stop
        S_RX: if (scl_rise) begin
          sh_q  <= b[6:0];
          bit_q <= bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_q <= S_ACK;
            if (idx_q != IDX_D2) begin
              idx_q <= smre_idx_t'(idx_q + 2'h1);
            end
          end
        end
        S_ACK: if (scl_fall) begin
          if (!ackon_q) begin
            sda_oe  <= ack_q;
            ackon_q <= 1'b1;
          end else begin
            ackon_q <= 1'b0;
            if (!ack_q) begin
              sda_oe <= 1'b0;
              st_q   <= S_SKIP;
            end else if (rd_q) begin
              tx_q   <= rd_byte;
              sda_oe <= ~rd_byte[7];
              st_q   <= S_TX;
            end else begin
              sda_oe <= 1'b0;
              st_q   <= S_RX;
            end
          end
        end
        S_TX: begin
          if (scl_rise) begin
            bit_q <= bit_q + 3'h1;
          end else if (scl_fall) begin
            if (bit_q == 3'h0) begin
              sda_oe <= 1'b0;
              st_q   <= S_TXACK;
            end else begin
              tx_q   <= {tx_q[6:0], 1'b0};
              sda_oe <= ~tx_q[6];
            end
          end
        end
        S_TXACK: if (scl_rise) begin
          // single byte read only; further clocks read idle high
          st_q <= S_SKIP;
        end
      endcase
    end
  end
  // =====================================================================
  // captured fields, pointer and control copy
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      ack_q  <= 1'b0;
      rd_q   <= 1'b0;
      cmd_q  <= 8'h00;
      lo_q   <= 8'h00;
      dcnt_q <= 6'h00;
      ptr_q  <= 16'h0000;
      dead_q <= 1'b0;
      wen_q  <= 1'b0;
    end else if (bus_start) begin
      rd_q   <= 1'b0;
      dcnt_q <= 6'h00;
    end else if (byte_done) begin
      ack_q <= ack_n;
      if (idx_q == IDX_ADDR) rd_q <= b[0];
      if (idx_q == IDX_CMD) cmd_q <= b;
      if (idx_q == IDX_D1) lo_q <= b;
      if ((idx_q == IDX_D2) && (dcnt_q != 6'h3f)) dcnt_q <= dcnt_q + 6'h01;
      if (ram_w && (ram_a == CTRL_REG)) wen_q <= b[CTRL_WEN];
      if (ptr_ld) begin
        ptr_q  <= ptr_nx;
        dead_q <= 1'b0;
      end else if (step) begin
        // stop at a page or area end instead of crossing it
        if (ptr_end) dead_q <= 1'b1;
        else ptr_q <= ptr_q + 16'h0001;
      end
    end
  end
  // =====================================================================
  // eeprom engine: one erase or one program at a time
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      nv_q     <= NV_IDLE;
      nv_cnt_q <= '0;
      wipe_q   <= 6'h00;
      paddr_q  <= 9'h000;
      pdata_q  <= 8'h00;
    end else if (nv_q == NV_IDLE) begin
      if (byte_done && era_go) begin
        nv_q     <= NV_ERASE;
        nv_cnt_q <= NV_CNT_W'(ERASE_CYC);
        wipe_q   <= 6'h00;
        paddr_q  <= {lo_q[0], b[7:5], 5'h00};
      end else if (byte_done && prog_go) begin
        nv_q     <= NV_PROG;
        nv_cnt_q <= NV_CNT_W'(PROG_CYC);
        paddr_q  <= ptr_idx;
        pdata_q  <= b;
      end
    end else begin
      nv_cnt_q <= nv_cnt_q - NV_CNT_W'(1);
      if (!wipe_q[5]) wipe_q <= wipe_q + 6'h01;
      if (nv_cnt_q == NV_CNT_W'(1)) nv_q <= NV_IDLE;
    end
  end
  // =====================================================================
  // status outputs from flops; reset folds into the busy terms
  always_ff @(posedge clock) begin
    sda_out    <= 1'b0;
    erase_busy <= reset_n & (nv_q == NV_ERASE);
    prog_busy  <= reset_n & (nv_q == NV_PROG);
  end
endmodule : smre_top
`default_nettype wire

/* File: verilog/smre_pkg.sv */
// smre_pkg: constants, write-port carrier and state types for the
// serial-bus RAM / EEPROM write and erase slave.
// assumes a 10 MHz system clock; the bus clock is sampled, not used as a clock.
package smre_pkg;
  // =====================================================================
  // timing
  localparam int CLK_PERIOD_NS = 100;       // system clock period
  localparam int ERASE_MS      = 20;        // page erase time
  localparam int PROG_US       = 350;       // one byte programming time
  localparam int PROG_CYC      = (PROG_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_CYC_DEF = (ERASE_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int NV_CNT_W      = 25;        // wide enough for the erase count

  // =====================================================================
  // command and address values
  localparam logic [7:0] CMD_BLK_WR  = 8'ha0;  // block write announce
  localparam logic [7:0] CMD_ERASE   = 8'ha2;  // page erase
  localparam logic [7:0] HI_USER     = 8'h80;  // user_field_data area high byte
  localparam logic [7:0] HI_DFLT     = 8'h81;  // register-default area high byte
  localparam logic [7:0] HI_RAM      = 8'h00;  // high byte of a volatile pointer
  localparam logic [7:0] DFLT_END_LO = 8'h3f;  // last valid low byte in 81xxh
  localparam logic [6:0] RAM_END     = 7'h7f;  // last volatile register
  localparam logic [4:0] PAGE_END    = 5'h1f;  // last byte offset in a page
  localparam logic [6:0] CTRL_REG    = 7'h03;  // eeprom control register
  localparam int         CTRL_WEN    = 1;      // single byte program enable bit
  localparam logic [7:0] BLK_MAX     = 8'h20;  // largest block count
  localparam logic [7:0] ERASED      = 8'hff;  // value of an erased cell
  localparam int         PAGE_BYTES  = 32;
  localparam int         PAGES       = 16;
  localparam logic [15:0] DFLT_BASE  = 16'h8100; // power-up default page

  // =====================================================================
  // types
  typedef struct packed {
    logic       en;
    logic [8:0] addr;
    logic [7:0] data;
  } smre_wr_t;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK, S_SKIP} smre_st_t;
  typedef enum logic [1:0] {NV_IDLE, NV_ERASE, NV_PROG} smre_nv_t;
  typedef enum logic [1:0] {IDX_ADDR, IDX_CMD, IDX_D1, IDX_D2} smre_idx_t;
endpackage : smre_pkg

/* File: verilog/smre_sync.sv */
// smre_sync: two-flop synchroniser for levels from outside the clock domain.
// assumes each bit is an independent slow level.
`timescale 1ns/1ns
`default_nettype none
module smre_sync
  import smre_pkg::*;
#(
  parameter int W = 1
) (
  input  wire logic         clock,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  // =====================================================================
  // sync stages
  logic [W-1:0] meta_q;   // first stage, read only by the second

  // two flops, synchronous reset to zero
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      meta_q <= '0;
      q      <= '0;
    end else begin
      meta_q <= d;
      q      <= meta_q;
    end
  end
endmodule : smre_sync
`default_nettype wire

/* File: verilog/smre_mem.sv */
// smre_mem: byte memory with one write port and a registered read port.
// assumes contents are undefined after power-up; no reset clears them.
`timescale 1ns/1ns
`default_nettype none
module smre_mem
  import smre_pkg::*;
#(
  parameter int AW = 9
) (
  input  wire logic          clock,
  input  wire smre_wr_t      wr,
  input  wire logic [AW-1:0] raddr,
  output var  logic [7:0]    rdata
);
  // =====================================================================
  // storage
  logic [7:0] mem [2**AW];   // byte array

  // write when enabled, read every cycle
  always_ff @(posedge clock) begin
    if (wr.en) begin
      mem[wr.addr[AW-1:0]] <= wr.data;
    end
    rdata <= mem[raddr];
  end
endmodule : smre_mem
`default_nettype wire

/* File: dv/smre_top_assertions.sv */
// smre_top_assertions: port-level checks for the serial-bus write/erase slave.
// assumes the bench drives scl_in and sda_in from a master model.
`timescale 1ns/1ns
`default_nettype none
module smre_top_checker
  import smre_pkg::*;
#(
  parameter int ERASE_CYC = ERASE_CYC_DEF
) (
  input wire logic       clock,
  input wire logic       reset_n,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic [6:0] dev_addr,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       erase_busy,
  input wire logic       prog_busy
);
  // ====================
  // busy length counters, cleared whenever the flag is low
  logic [NV_CNT_W-1:0] erase_cnt_q;  // cycles erase flag has stood
  logic [NV_CNT_W-1:0] prog_cnt_q;   // cycles program flag has stood
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      erase_cnt_q <= '0;
      prog_cnt_q  <= '0;
    end else begin
      erase_cnt_q <= erase_busy ? erase_cnt_q + 1'b1 : '0;
      prog_cnt_q  <= prog_busy ? prog_cnt_q + 1'b1 : '0;
    end
  end

  // ====================
  // properties, all on the system clock
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  reset_quiet_a: assert property (disable iff (1'b0) !reset_n |=>
    !sda_oe && !erase_busy && !prog_busy) else $error("outputs active after reset");
  open_drain_a: assert property (sda_oe |-> !sda_out)
    else $error("sda driven high");
  ack_in_low_a: assert property ($changed(sda_oe) |-> !scl_in)
    else $error("sda changed while scl high");
  busy_exclusive_a: assert property (!(erase_busy && prog_busy))
    else $error("erase and program together");
  erase_len_a: assert property ($fell(erase_busy) |-> erase_cnt_q == ERASE_CYC)
    else $error("erase length wrong");
  prog_len_a: assert property ($fell(prog_busy) |-> prog_cnt_q == PROG_CYC)
    else $error("program length wrong");
  erase_ack_a: assert property ($rose(erase_busy) |-> ##[1:16] $rose(sda_oe))
    else $error("erase start without ack");
  prog_ack_a: assert property ($rose(prog_busy) |-> ##[1:16] $rose(sda_oe))
    else $error("program start without ack");

  c_erase: cover property ($fell(erase_busy));
  c_prog: cover property ($fell(prog_busy));
  c_ack: cover property ($rose(sda_oe));
endmodule : smre_top_checker

bind smre_top smre_top_checker #(
  .ERASE_CYC(ERASE_CYC)
) smre_top_checker_inst (
  .clock(clock), .reset_n(reset_n), .scl_in(scl_in), .sda_in(sda_in),
  .dev_addr(dev_addr), .sda_out(sda_out), .sda_oe(sda_oe),
  .erase_busy(erase_busy), .prog_busy(prog_busy)
);
`default_nettype wire

/* File: dv/smre_master_model.sv */
// smre_master_model: behavioural bus master clocking the link at 800 ns.
// assumes a pull-up on sda: the bench resolves the wire from both enables.
`timescale 1ns/1ns
`default_nettype none
module smre_master_model (
  input  wire logic sda,      // resolved wire level
  output var  logic scl,      // bus clock, stands high between frames
  output var  logic sda_low   // high pulls sda low
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end
  // start, or repeated start when called mid-frame with scl low
  task automatic start_c();
    sda_low = 1'b0;
    #200 scl = 1'b1;
    #200 sda_low = 1'b1;
    #200 scl = 1'b0;
    #200;
  endtask : start_c
  // stop, then leave the bus free a while
  task automatic stop_c();
    sda_low = 1'b1;
    #200 scl = 1'b1;
    #200 sda_low = 1'b0;
    #400;
  endtask : stop_c
  // one bit: data moves only in scl low, sampled mid-high
  task automatic bit_x(input logic o, output logic i);
    sda_low = !o;
    #200 scl = 1'b1;
    #200 i = sda;
    #200 scl = 1'b0;
    #200;
  endtask : bit_x
  // eight bits msb first, then a released ack slot
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx, output logic ack);
    logic a;
    for (int i = 7; i >= 0; i--) bit_x(tx[i], rx[i]);
    bit_x(1'b1, a);
    ack = !a;
  endtask : xfer
endmodule : smre_master_model
`default_nettype wire

/* File: dv/test_smbus_ram_eeprom_write_erase.sv */
// test_smbus_ram_eeprom_write_erase: self-checking bench for smre_top.
// assumes the master model owns scl; erase time shortened to 2000 cycles.
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, exp, got) \
  begin \
    tests_run++; \
    if ((got) !== (exp)) begin \
      fails++; \
      $display("unexpected %s expected %h seen %h", nm, exp, got); \
    end \
  end
module test_smbus_ram_eeprom_write_erase;
  import smre_pkg::*;
  localparam logic [7:0] WR = 8'ha0;  // slave 50h, write
  localparam logic [7:0] RD = 8'ha1;  // slave 50h, read
  logic       clock, reset_n, scl, sda, m_low;
  logic       sda_out, sda_oe, erase_busy, prog_busy;
  logic [6:0] dev_addr;               // address straps
  int         fails, tests_run;
  // ====================
  // open-drain wire with pull-up
  assign sda = !(sda_oe || m_low);
  smre_top #(.ERASE_CYC(2000)) smre_top_inst (
    .clock(clock), .reset_n(reset_n), .scl_in(scl), .sda_in(sda),
    .dev_addr(dev_addr), .sda_out(sda_out), .sda_oe(sda_oe),
    .erase_busy(erase_busy), .prog_busy(prog_busy));
  smre_master_model smre_master_model_inst (.sda(sda), .scl(scl), .sda_low(m_low));
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  // ====================
  // bus helpers
  task automatic st(); smre_master_model_inst.start_c(); endtask : st
  task automatic sp(); smre_master_model_inst.stop_c(); endtask : sp
  task automatic send(input logic [7:0] b, input logic exp);
    logic [7:0] r;
    logic a;
    smre_master_model_inst.xfer(b, r, a);
    `CHK("ack", exp, a)
  endtask : send
  // write frame: command plus n data bytes, optional stop
  task automatic wframe(input logic [7:0] c, d1, d2, input int n, input bit stop);
    st();
    send(WR, 1'b1);
    send(c, 1'b1);
    if (n > 0) send(d1, 1'b1);
    if (n > 1) send(d2, 1'b1);
    if (stop) sp();
  endtask : wframe
  // single-byte read at the pointer; repeated start if no stop came before
  task automatic rd(input logic [7:0] exp);
    logic [7:0] r;
    logic a;
    st();
    send(RD, 1'b1);
    smre_master_model_inst.xfer(8'hff, r, a);
    sp();
    `CHK("read data", exp, r)
  endtask : rd
  // bounded wait for the memory engine to go quiet
  task automatic idle();
    int k;
    k = 0;
    while ((erase_busy !== 1'b0 || prog_busy !== 1'b0) && k < 20000) begin
      @(posedge clock);
      k++;
    end
    if (k >= 20000) begin
      fails++;
      $display("unexpected engine busy expected 0 seen 1");
      print_verdict();
    end
    #5;
  endtask : idle
  // ====================
  // scenarios
  task automatic s_regs();
    wframe(8'h10, 8'h5c, 8'h77, 2, 1);
    wframe(8'h10, 8'h00, 8'h00, 0, 0);
    rd(8'h5c);
    `CHK("sda_out", 1'b0, sda_out)
    st();
    send({7'h51, 1'b0}, 1'b0);
    sp();
    wframe(CTRL_REG, 8'h02, 8'h00, 1, 1);
  endtask : s_regs
  task automatic s_erase();
    wframe(CMD_ERASE, HI_USER, 8'h3f, 2, 1);
    `CHK("erase_busy", 1'b1, erase_busy)
    st();
    send(WR, 1'b1);
    send(HI_USER, 1'b0);
    sp();
    idle();
    wframe(HI_USER, 8'h21, 8'h00, 1, 0);
    rd(ERASED);
  endtask : s_erase
  task automatic s_prog();
    wframe(HI_USER, 8'h21, 8'ha5, 2, 1);
    `CHK("prog_busy", 1'b1, prog_busy)
    st();
    send(WR, 1'b1);
    send(HI_DFLT, 1'b0);
    sp();
    idle();
    wframe(HI_USER, 8'h21, 8'h00, 1, 0);
    rd(8'ha5);
    wframe(HI_USER, 8'h21, 8'h5a, 2, 1);
    idle();
    wframe(HI_USER, 8'h21, 8'h00, 1, 0);
    rd(8'h00);
    wframe(CTRL_REG, 8'h00, 8'h00, 1, 1);
    wframe(HI_USER, 8'h22, 8'h12, 2, 1);
    `CHK("prog_busy", 1'b0, prog_busy)
    wframe(HI_USER, 8'h22, 8'h00, 1, 0);
    rd(ERASED);
    // block write into the erased page; single-byte enable bit left clear at 03h
    wframe(HI_USER, 8'h23, 8'h00, 1, 1);
    wframe(CMD_BLK_WR, 8'h02, 8'h00, 1, 0);
    send(8'h3c, 1'b1);
    send(8'h44, 1'b0);
    sp();
    idle();
    wframe(HI_USER, 8'h23, 8'h00, 1, 0);
    rd(8'h3c);
  endtask : s_prog
  task automatic s_block();
    wframe(8'h7e, 8'h00, 8'h00, 0, 1);
    wframe(CMD_BLK_WR, 8'h03, 8'h00, 1, 0);
    for (int i = 1; i <= 3; i++) send(8'(8'h11 * i), 1'b1);
    sp();
    rd(8'h00);
    wframe(8'h7e, 8'h00, 8'h00, 0, 0);
    rd(8'h11);
    wframe(8'h7f, 8'h00, 8'h00, 0, 0);
    rd(8'h22);
    wframe(CMD_BLK_WR, 8'h00, 8'h00, 0, 0);
    send(8'h21, 1'b0);
    sp();
  endtask : s_block
  // ====================
  // single place where the run ends
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict
  initial begin
    reset_n = 1'b0;
    dev_addr = 7'h50;
    fails = 0;
    tests_run = 0;
    repeat (3) @(posedge clock);
    #5 reset_n = 1'b1;
    repeat (3) @(posedge clock);
    #5;
    s_regs();
    s_erase();
    s_prog();
    s_block();
    print_verdict();
  end
endmodule : test_smbus_ram_eeprom_write_erase
`default_nettype wire
